/* bench/sbr_rate_gen_asserts.sv */
// checker: register port and rate enable properties
`timescale 1ns/100ps
`default_nettype none
module sbr_rate_gen_asserts
  import sbr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire sbr_bus_req_t bus_i,
  input wire logic [7:0] rdata_o,
  input wire logic rate_en_o,
  input wire logic rate_x16_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  rd_bits_a: assert property (bus_i.rd |=> rdata_o[7:6] == 2'h0 && !rdata_o[3])
    else $error("spare bits set");
  hold_a: assert property (!bus_i.rd |=> $stable(rdata_o)) else $error("rdata moved");
  echo_a: assert property (bus_i.wr && bus_i.addr == 4'h0 ##1 bus_i.rd && bus_i.addr == 4'h0
    |=> rdata_o == ($past(bus_i.wdata, 2) & 8'h37)) else $error("bad readback");
  unmapped_a: assert property (bus_i.rd && bus_i.addr > 4'h1 |=> rdata_o == 8'h00)
    else $error("unmapped read");
  en_gap_a: assert property (rate_en_o |=> !rate_en_o [*8]) else $error("rate gap");
  x16_gap_a: assert property (rate_x16_o |=> !rate_x16_o [*3]) else $error("x16 gap");
  x16_due_a: assert property (rate_x16_o |-> ##[4:52] rate_x16_o) else $error("x16 late");
endmodule
bind sbr_rate_gen sbr_rate_gen_asserts u_chk (.*);
`default_nettype wire

/* bench/testbench.sv */
// bench: select register and bit rate period checks
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sbr_pkg::*;
  logic sys_clk_i = 0, arst_n_i = 0, rate_en_o, rate_x16_o;
  logic [7:0] rdata_o;
  logic [31:0] seed = 32'hbbf88584;
  sbr_bus_req_t bus_i = '0;
  int fail_count = 0, comparisons = 0, cyc = 0, n;
  int pdv[4] = '{1, 3, 4, 13};
  `define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", nm, e, s); end end
  sbr_rate_gen dut (.*);
  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      wrap_up;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // request stands through the sampling edge; the caller or next access replaces it
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] v);
    bus_i <= '{addr: a, wdata: v, wr: w, rd: !w};
    @(posedge sys_clk_i);
  endtask
  // read data appear in the cycle after the strobe and hold until the next read: look at mid-cycle
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    bus_i <= '0;
    @(negedge sys_clk_i);
    `CHK("rdata", e, rdata_o)
    @(posedge sys_clk_i);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk_i);
    arst_n_i <= 1;
    @(posedge sys_clk_i);
    for (int a = 0; a < 3; a++) rd(a[3:0], 8'h00);
    for (int i = 0; i < 20; i++) begin
      seed = xs(seed);
      acc(1'b1, 4'h0, i == 0 ? 8'hff : seed[7:0]);
      rd(4'h0, (i == 0 ? 8'hff : seed[7:0]) & 8'h37);
    end
    $display("register test done");
    for (int p = 0; p < 4; p++) begin
      acc(1'b1, 4'h0, {2'h0, p[1:0], 1'h0, p[2:0]});
      bus_i <= '0;
      repeat (3) @(posedge rate_en_o);
      n = 0;
      do begin
        @(posedge sys_clk_i);
        #1 n++;
      end while (!rate_en_o);
      `CHK("period", 64 * pdv[p] * (1 << p), n)
      rd(4'h1, {2'h0, p[1:0], 1'h0, p[2:0]});
      $display("rate test %0d done", p);
    end
    wrap_up;
  end
endmodule
`default_nettype wire

/* rtl/sbr_div_stage.sv */
// one divide-by-n stage advanced by an enable
`timescale 1ns/100ps
`default_nettype none
module sbr_div_stage #(
  parameter int CNT_W = 8
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic en_i,
  input wire logic [CNT_W-1:0] ratio_i,
  output logic tick_o
);
  logic [CNT_W-1:0] cnt;
  wire last = (cnt >= ratio_i - {{(CNT_W-1){1'b0}}, 1'b1});
  assign tick_o = en_i & last;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= '0;
    end else if (en_i) begin
      cnt <= last ? '0 : cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

/* rtl/sbr_pkg.sv */
// package: constants and types of the serial bit rate generator
package sbr_pkg;
  localparam int SBR_ADDR_W = 4;
  localparam logic [3:0] SBR_OFF_SELECT = 4'h0;
  localparam logic [3:0] SBR_OFF_STATUS = 4'h1;
  localparam int SBR_RATE_LSB = 0;
  localparam int SBR_RATE_MSB = 2;
  localparam int SBR_PRE_LSB = 4;
  localparam int SBR_PRE_MSB = 5;
  localparam logic [7:0] SBR_SELECT_RESET = 8'h00;
  localparam int SBR_FIXED_DIV = 64;
  localparam int SBR_CNT_W = 8;
  localparam logic [7:0] SBR_PD_CODE0 = 8'h01;
  localparam logic [7:0] SBR_PD_CODE1 = 8'h03;
  localparam logic [7:0] SBR_PD_CODE2 = 8'h04;
  localparam logic [7:0] SBR_PD_CODE3 = 8'h0d;

  typedef struct packed {
    logic [1:0] prescale_select;
    logic [2:0] rate_divisor_select;
  } sbr_select_t;

  typedef struct packed {
    logic [SBR_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sbr_bus_req_t;
endpackage

/* rtl/sbr_rate_gen.sv */
// serial bit rate generator: register port and divider chain
// Notes on behaviour
// [R1] one rate enable times receiver and transmitter
// [R2] prescale codes give divisors 1,3,4,13
// [R3] reset clears prescale select
// [R4] rate select divides by two to code
// [R5] bit rate is clock/(64*pd*bd)
// [R6] both fields read back last write
// [R7] new selection applies at terminal count
`timescale 1ns/100ps
`default_nettype none
module sbr_rate_gen
  import sbr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire sbr_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  output logic rate_en_o,
  output logic rate_x16_o
);
  ////////////////////////////////////////////////////////////////////
  logic [7:0] select_reg;
  sbr_select_t active;
  logic [7:0] rate_cnt;
  logic [7:0] pd_ratio;

  wire wr_select = bus_i.wr && (bus_i.addr == SBR_OFF_SELECT);
  wire sbr_select_t written = '{prescale_select: select_reg[SBR_PRE_MSB:SBR_PRE_LSB],
                                rate_divisor_select: select_reg[SBR_RATE_MSB:SBR_RATE_LSB]};
  wire [7:0] rd_mux = (bus_i.addr == SBR_OFF_SELECT) ? select_reg :  // [R6]
                      (bus_i.addr == SBR_OFF_STATUS) ?
                      {2'b00, active.prescale_select, 1'b0, active.rate_divisor_select} :
                      8'h00;

  ////////////////////////////////////////////////////////////////////
  // prescaler, then fixed /4 to the x16 oversample, then /16 to reach the 64 factor
  always_comb begin
    unique case (active.prescale_select)  // [R2]
      2'b00: pd_ratio = SBR_PD_CODE0;
      2'b01: pd_ratio = SBR_PD_CODE1;
      2'b10: pd_ratio = SBR_PD_CODE2;
      2'b11: pd_ratio = SBR_PD_CODE3;
    endcase
  end

  logic pd_tick;
  logic x16_tick;
  logic base_tick;
  sbr_div_stage #(.CNT_W(SBR_CNT_W)) u_pre (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .en_i(1'b1),
    .ratio_i(pd_ratio),
    .tick_o(pd_tick)
  );
  sbr_div_stage #(.CNT_W(SBR_CNT_W)) u_x4 (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .en_i(pd_tick),
    .ratio_i(SBR_CNT_W'(SBR_FIXED_DIV / 16)),
    .tick_o(x16_tick)
  );
  sbr_div_stage #(.CNT_W(SBR_CNT_W)) u_x16 (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .en_i(x16_tick),
    .ratio_i(SBR_CNT_W'(16)),
    .tick_o(base_tick)
  );  // [R5]

  // rate divisor counts base ticks; terminal count is 2**select - 1
  wire [7:0] bd_last = (8'h01 << active.rate_divisor_select) - 8'h01;  // [R4]
  wire bd_done = base_tick && (rate_cnt >= bd_last);
  wire div_wrap = pd_tick && x16_tick && base_tick;

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      select_reg <= SBR_SELECT_RESET;  // [R3]
      active <= '0;
      rate_cnt <= '0;
      rdata_o <= '0;
      rate_en_o <= 1'b0;
      rate_x16_o <= 1'b0;
    end else begin
      if (wr_select) begin
        select_reg <= bus_i.wdata & 8'h37;  // [R6]
      end
      if (bus_i.rd) begin
        rdata_o <= rd_mux;
      end
      if (bd_done || (div_wrap && rate_cnt == 8'h00 && bd_last == 8'h00)) begin
        active <= written;  // [R7]
      end
      if (base_tick) begin
        rate_cnt <= bd_done ? 8'h00 : rate_cnt + 8'h01;
      end
      rate_en_o <= bd_done;  // [R1]
      rate_x16_o <= x16_tick;
    end
  end
endmodule
`default_nettype wire
